//--- hdl/spdg_pkg.sv
// Purpose: Shared constants, types and helpers of the spindle direction and gear control.
// Assumes: AHB-Lite register access, 32-bit word registers, 100 MHz mclk.
// Notes: Byte offsets are word aligned; the low address byte selects the register.
package spdg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] GEAR_OFS = 8'h04;
  localparam logic [7:0] CFG_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] SPD1_OFS = 8'h10;
  localparam logic [7:0] SPD2_OFS = 8'h14;
  localparam logic [7:0] SPD3_OFS = 8'h18;
  localparam logic [7:0] FRAT_OFS = 8'h1c;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // Spindle command codes written to the command register
  // ----------------------------------------------------------------
  localparam logic [7:0] SPINDLE_FORWARD_CODE = 8'h03;
  localparam logic [7:0] SPINDLE_REVERSE_CODE = 8'h04;
  localparam logic [7:0] SPINDLE_STOP_CODE = 8'h05;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int CFG_RATIO_LO = 0;
  localparam int CFG_RATIO_HI = 1;
  localparam int CFG_FREE = 2;
  localparam int CFG_CTYPE = 3;
  localparam int CFG_AUTO = 4;
  localparam int CFG_DETECT = 5;
  localparam int CFG_IOPT = 6;
  localparam int CFG_W = 7;
  localparam logic [CFG_W-1:0] CFG_RST = 7'h20;

  localparam int SPD_W = 16;
  localparam int RATIO_W = 8;
  localparam logic [RATIO_W-1:0] RATIO_BASE = 8'h01;
  localparam logic [RATIO_W-1:0] FRAT_RST = 8'h01;

  localparam logic [1:0] GEAR_NONE = 2'h0;
  localparam logic [1:0] GEAR_ONE = 2'h1;
  localparam logic [1:0] GEAR_THREE = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {SH_IDLE = 1'b0, SH_WAIT = 1'b1} spdg_shift_state_type;

  typedef struct packed {
    logic [7:0] zero_pad;
    logic [2:0] gear_inpos;
    logic mode_shift_done;
    logic orientation_done;
    logic zero_speed_detected;
    logic speed_reached;
    logic drive_enable;
    logic stop;
    logic reverse;
    logic forward;
    logic cfg_mismatch;
    logic speed_order_err;
    logic shift_busy;
    logic [1:0] cur_gear;
    logic [RATIO_W-1:0] eff_ratio;
  } spdg_stat_type;

  // Fixed encoder ratio from the two-bit select, high bit first.
  function automatic logic [RATIO_W-1:0] ratio_decode(input logic [1:0] sel);
    ratio_decode = RATIO_BASE << sel;
  endfunction

  // One request line per gear; gear 0 gives no line.
  function automatic logic [2:0] gear_onehot(input logic [1:0] gear);
    gear_onehot = (gear == GEAR_NONE) ? 3'h0 : 3'(3'h1 << (gear - GEAR_ONE));
  endfunction

endpackage

//--- hdl/spdg_shift_if.sv
// Purpose: Carries a gear change request and its progress between the control and sequencer.
// Assumes: Both ends run on mclk.
// Notes: Inputs carried here are already synchronised.
`timescale 1ns/100ps
`default_nettype none
interface spdg_shift_if;
  logic start;
  logic [1:0] gear;
  logic detect;
  logic [2:0] inpos;
  logic busy;
  logic [1:0] cur_gear;
  logic [2:0] gear_req;

  modport ctrl (output start, output gear, output detect, output inpos,
    input busy, input cur_gear, input gear_req);
  modport seq (input start, input gear, input detect, input inpos,
    output busy, output cur_gear, output gear_req);
endinterface
`default_nettype wire

//--- hdl/spdg_gear_shift.sv
// Purpose: Runs one gear change: raises one request line and waits for its in-position switch.
// Assumes: start is only given while idle.
// Notes: Without detection switches the change completes one cycle after the request.
`timescale 1ns/100ps
`default_nettype none
module spdg_gear_shift
  import spdg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  spdg_shift_if.seq sif
);

  spdg_shift_state_type state_r;
  logic [2:0] gear_req_r;
  logic [1:0] tgt_r;
  logic [1:0] cur_gear_r;
  logic arrived;

  assign arrived = !sif.detect || ((sif.inpos & gear_req_r) != 3'h0);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= SH_IDLE;
      gear_req_r <= 3'h0;
      tgt_r <= GEAR_NONE;
    end
    else
    begin
      unique case (state_r)
        SH_IDLE:
        begin
          if (sif.start)
          begin
            state_r <= SH_WAIT;
            gear_req_r <= gear_onehot(sif.gear);
            tgt_r <= sif.gear;
          end
        end
        SH_WAIT:
        begin
          if (arrived)
          begin
            state_r <= SH_IDLE;
            gear_req_r <= 3'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cur_gear_r <= GEAR_ONE;
    else if (state_r == SH_WAIT && arrived)
      cur_gear_r <= tgt_r;
  end

  assign sif.busy = (state_r == SH_WAIT);
  assign sif.gear_req = gear_req_r;
  assign sif.cur_gear = cur_gear_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  req_onehot_a: assert property (sif.busy |-> $onehot(gear_req_r))
    else $error("Gear request is not exactly one line during a change.");
  idle_quiet_a: assert property (!sif.busy |-> gear_req_r == 3'h0)
    else $error("Gear request line raised while idle.");
  no_detect_a: assert property (sif.busy && !sif.detect |=> !sif.busy)
    else $error("Change waited for a switch that is not fitted.");
  wait_inpos_a: assert property (sif.busy && sif.detect
    && ((sif.inpos & gear_req_r) == 3'h0) |=> sif.busy && $stable(gear_req_r))
    else $error("Change ended before its in-position switch closed.");
  done_gear_a: assert property ($fell(sif.busy) |-> cur_gear_r == $past(tgt_r))
    else $error("Current gear does not match the finished change.");

endmodule
`default_nettype wire

//--- hdl/spdg_spindle_ctrl.sv
// Purpose: Spindle direction, stop, drive enable and automatic gear change with AHB-Lite registers.
// Assumes: Drive and gearbox signals are asynchronous pins; one clock mclk.
// Notes: Zero-wait slave; unmapped reads return zero and unmapped writes are dropped.
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - stop output held from reset until run
// - run command sets direction, drops stop
// - forward, reverse, enable drive their pins
// - encoder ratio select decodes to 1,2,4,8
// - free ratio select allows any ratio
// - control type one means I/O control
// - three-step gear change under frequency control
// - gear requests on three outputs
// - no auto shift fitted shows gear one in status; the gear register keeps the last gear
// - without auto shift, speeds must descend
// - no detection switch skips in-position wait
// - I/O control needs its config bit set
module spdg_spindle_ctrl
  import spdg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic spindle_forward_out,
  output logic spindle_reverse_out,
  output logic spindle_drive_enable,
  output logic spindle_stop_out,
  output logic [2:0] gear_req_out,
  input wire logic speed_reached,
  input wire logic zero_speed_detected,
  input wire logic orientation_done,
  input wire logic mode_shift_done,
  input wire logic [2:0] gear_inpos
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pin_meta_r;
  logic [6:0] pin_sync_r;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_meta_r <= 7'h00;
      pin_sync_r <= 7'h00;
    end
    else
    begin
      pin_meta_r <= {gear_inpos, mode_shift_done, orientation_done,
        zero_speed_detected, speed_reached};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic addr_take;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_word;

  assign addr_take = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_take && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      hrdata_r <= 32'h0;
    else if (addr_take && !hwrite)
      hrdata_r <= rd_word;
  end

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_pend_r && (wr_addr_r == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Configuration and speed registers
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg_r;
  logic [SPD_W-1:0] spd1_r;
  logic [SPD_W-1:0] spd2_r;
  logic [SPD_W-1:0] spd3_r;
  logic [RATIO_W-1:0] frat_r;
  logic [7:0] last_code_r;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cfg_r <= CFG_RST;
    else if (wr_hit(CFG_OFS))
      cfg_r <= hwdata[CFG_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      spd1_r <= '0;
      spd2_r <= '0;
      spd3_r <= '0;
      frat_r <= FRAT_RST;
    end
    else
    begin
      if (wr_hit(SPD1_OFS))
        spd1_r <= hwdata[SPD_W-1:0];
      if (wr_hit(SPD2_OFS))
        spd2_r <= hwdata[SPD_W-1:0];
      if (wr_hit(SPD3_OFS))
        spd3_r <= hwdata[SPD_W-1:0];
      if (wr_hit(FRAT_OFS))
        frat_r <= hwdata[RATIO_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Derived status
  // ----------------------------------------------------------------
  logic [RATIO_W-1:0] eff_ratio_r;
  logic speed_order_err_r;
  logic cfg_mismatch_r;
  logic io_ctl;
  logic auto_fitted;

  assign io_ctl = cfg_r[CFG_CTYPE];
  assign auto_fitted = cfg_r[CFG_AUTO];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      eff_ratio_r <= RATIO_BASE;
    else if (cfg_r[CFG_FREE])
      eff_ratio_r <= frat_r;
    else
      eff_ratio_r <= ratio_decode({cfg_r[CFG_RATIO_HI], cfg_r[CFG_RATIO_LO]});
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      speed_order_err_r <= 1'b0;
      cfg_mismatch_r <= 1'b0;
    end
    else
    begin
      speed_order_err_r <= !auto_fitted && ((spd1_r < spd2_r) || (spd2_r < spd3_r));
      cfg_mismatch_r <= io_ctl && !cfg_r[CFG_IOPT];
    end
  end

  // ----------------------------------------------------------------
  // Gear change request
  // ----------------------------------------------------------------
  spdg_shift_if sif ();
  logic shift_go;
  logic [1:0] gear_wr;

  assign gear_wr = hwdata[1:0];
  // Changes run only under frequency control with the changer fitted.
  assign shift_go = wr_hit(GEAR_OFS) && auto_fitted && !io_ctl && !sif.busy
    && (gear_wr != GEAR_NONE);
  assign sif.start = shift_go;
  assign sif.gear = gear_wr;
  assign sif.detect = cfg_r[CFG_DETECT];
  assign sif.inpos = pin_sync_r[6:4];

  spdg_gear_shift u_shift (
    .mclk(mclk),
    .rst_n(rst_n),
    .sif(sif)
  );

  // ----------------------------------------------------------------
  // Spindle direction
  // ----------------------------------------------------------------
  logic [7:0] code_wr;
  logic run_fwd;
  logic run_rev;
  logic run_stop;
  logic fwd_r;
  logic rev_r;
  logic stop_r;
  logic hold_run;

  assign code_wr = hwdata[7:0];
  assign run_fwd = wr_hit(CMD_OFS) && (code_wr == SPINDLE_FORWARD_CODE);
  assign run_rev = wr_hit(CMD_OFS) && (code_wr == SPINDLE_REVERSE_CODE);
  assign run_stop = wr_hit(CMD_OFS) && (code_wr == SPINDLE_STOP_CODE);
  // The spindle pauses while a gear change is running.
  assign hold_run = sif.busy || shift_go;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
      stop_r <= 1'b1;
      last_code_r <= SPINDLE_STOP_CODE;
    end
    else if (run_fwd || run_rev)
    begin
      fwd_r <= run_fwd;
      rev_r <= run_rev;
      stop_r <= 1'b0;
      last_code_r <= code_wr;
    end
    else if (run_stop)
    begin
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
      stop_r <= 1'b1;
      last_code_r <= code_wr;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      spindle_forward_out <= 1'b0;
      spindle_reverse_out <= 1'b0;
      spindle_drive_enable <= 1'b0;
      spindle_stop_out <= 1'b1;
      gear_req_out <= 3'h0;
    end
    else
    begin
      spindle_forward_out <= fwd_r && !hold_run;
      spindle_reverse_out <= rev_r && !hold_run;
      spindle_drive_enable <= (fwd_r || rev_r) && !hold_run;
      spindle_stop_out <= stop_r;
      gear_req_out <= sif.gear_req;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  spdg_stat_type stat;

  always_comb
  begin
    stat = '0;
    stat.eff_ratio = eff_ratio_r;
    stat.cur_gear = auto_fitted ? sif.cur_gear : GEAR_ONE;
    stat.shift_busy = sif.busy;
    stat.speed_order_err = speed_order_err_r;
    stat.cfg_mismatch = cfg_mismatch_r;
    stat.forward = spindle_forward_out;
    stat.reverse = spindle_reverse_out;
    stat.stop = spindle_stop_out;
    stat.drive_enable = spindle_drive_enable;
    stat.speed_reached = pin_sync_r[0];
    stat.zero_speed_detected = pin_sync_r[1];
    stat.orientation_done = pin_sync_r[2];
    stat.mode_shift_done = pin_sync_r[3];
    stat.gear_inpos = pin_sync_r[6:4];
  end

  always_comb
  begin
    rd_word = 32'h0;
    unique case (haddr[7:0])
      CMD_OFS: rd_word = {24'h0, last_code_r};
      GEAR_OFS: rd_word = {30'h0, sif.cur_gear};
      CFG_OFS: rd_word = {25'h0, cfg_r};
      STAT_OFS: rd_word = stat;
      SPD1_OFS: rd_word = {16'h0, spd1_r};
      SPD2_OFS: rd_word = {16'h0, spd2_r};
      SPD3_OFS: rd_word = {16'h0, spd3_r};
      FRAT_OFS: rd_word = {24'h0, frat_r};
      default: rd_word = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  stop_hold_a: assert property (stop_r && !run_fwd && !run_rev |=> stop_r)
    else $error("Stop released without a run command.");
  run_dir_a: assert property (run_fwd |=> fwd_r && !rev_r && !stop_r)
    else $error("Forward command did not set forward and drop stop.");
  run_rev_a: assert property (run_rev |=> ##1 spindle_stop_out == 1'b0)
    else $error("Stop pin still high after a reverse command.");
  enable_dir_a: assert property (spindle_drive_enable
    |-> spindle_forward_out ^ spindle_reverse_out)
    else $error("Drive enable without exactly one direction.");
  ratio_fixed_a: assert property (!$past(cfg_r[CFG_FREE])
    |-> $onehot(eff_ratio_r) && eff_ratio_r <= 8'h08)
    else $error("Fixed encoder ratio is not 1, 2, 4 or 8.");
  ratio_free_a: assert property ($past(cfg_r[CFG_FREE]) |-> eff_ratio_r == $past(frat_r))
    else $error("Free ratio not taken from its register.");
  io_noshift_a: assert property ((io_ctl || !auto_fitted) && !sif.busy |=> !sif.busy)
    else $error("Gear change started outside frequency control.");
  shift_pause_a: assert property (sif.busy |=> !spindle_drive_enable)
    else $error("Spindle driven during a gear change.");
  speed_order_a: assert property (!auto_fitted && spd1_r < spd2_r |=> speed_order_err_r)
    else $error("Descending speed violation not flagged.");
  io_cfg_a: assert property (io_ctl && !cfg_r[CFG_IOPT] |=> cfg_mismatch_r)
    else $error("I/O control without its config bit not flagged.");

endmodule
`default_nettype wire

//--- testbench/spdg_drive_model.sv
// Purpose: Behavioural spindle drive and gearbox switches for the spindle control bench.
// Assumes: Outputs of the control are registered and on mclk.
// Notes: slow stretches speed ramp and gear travel; hold_inpos models a gearbox without switches.
`timescale 1ns/100ps
`default_nettype none
module spdg_drive_model
  import spdg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fwd,
  input wire logic rev,
  input wire logic en,
  input wire logic [2:0] gear_req,
  input wire logic slow,
  input wire logic orient_cmd,
  input wire logic mode_cmd,
  input wire logic hold_inpos,
  output logic speed_reached,
  output logic zero_speed_detected,
  output logic orientation_done,
  output logic mode_shift_done,
  output logic [2:0] gear_inpos
);
  logic [3:0] spd_cnt;
  logic [3:0] gear_cnt;
  logic [2:0] engaged;
  logic run;
  logic moving;
  logic [3:0] lim;

  assign run = en & (fwd ^ rev);
  assign lim = slow ? 4'hc : 4'h3;
  assign moving = (gear_req != 3'h0) && (gear_req != engaged);

  // ----------------------------------------------------------------
  // Speed ramp
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      spd_cnt <= 4'h0;
    else if (run && spd_cnt != 4'hf)
      spd_cnt <= spd_cnt + 4'h1;
    else if (!run && spd_cnt != 4'h0)
      spd_cnt <= spd_cnt - 4'h1;
  end

  assign speed_reached = run && (spd_cnt >= lim);
  assign zero_speed_detected = (spd_cnt == 4'h0);
  assign orientation_done = orient_cmd;
  assign mode_shift_done = mode_cmd;

  // ----------------------------------------------------------------
  // Gearbox travel
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      engaged <= 3'h1;
      gear_cnt <= 4'h0;
    end
    else if (moving && gear_cnt == lim)
    begin
      engaged <= gear_req;
      gear_cnt <= 4'h0;
    end
    else if (moving)
      gear_cnt <= gear_cnt + 4'h1;
  end

  // No gear is in position while the box travels between gears.
  assign gear_inpos = (hold_inpos || moving) ? 3'h0 : engaged;
endmodule
`default_nettype wire

//--- testbench/test_spdg_spindle_ctrl.sv
// Purpose: Self-checking bench of the spindle direction and gear control.
// Assumes: Single AHB-Lite slave; hready is its own hreadyout.
// Notes: Waits are bounded; a spent bound ends the run as a failure.
`timescale 1ns/100ps
`default_nettype none
module test_spdg_spindle_ctrl
  import spdg_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, fwd, rev, en, stp;
  logic [31:0] hrdata;
  logic [2:0] gear_req, inpos;
  logic sr, zs, od, md;
  logic slow = 1'b0;
  logic orient_cmd = 1'b0;
  logic mode_cmd = 1'b0;
  logic hold_inpos = 1'b0;
  logic [31:0] rd;
  int n_mismatch = 0;
  int n_tests = 0;

  always #5 mclk = ~mclk;

  spdg_spindle_ctrl i_spdg_spindle_ctrl (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .spindle_forward_out(fwd), .spindle_reverse_out(rev), .spindle_drive_enable(en),
    .spindle_stop_out(stp), .gear_req_out(gear_req), .speed_reached(sr),
    .zero_speed_detected(zs), .orientation_done(od), .mode_shift_done(md), .gear_inpos(inpos));

  spdg_drive_model i_spdg_drive_model (.mclk(mclk), .rst_n(rst_n), .fwd(fwd), .rev(rev),
    .en(en), .gear_req(gear_req), .slow(slow), .orient_cmd(orient_cmd), .mode_cmd(mode_cmd),
    .hold_inpos(hold_inpos), .speed_reached(sr), .zero_speed_detected(zs),
    .orientation_done(od), .mode_shift_done(md), .gear_inpos(inpos));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      chk("hready wait", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask

  // One single word transfer; the address phase is held until hready is seen high.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd & m, exp);
  endtask

  task automatic pins(input string nm, input logic [3:0] exp);
    repeat (2) @(posedge mclk);
    #1;
    chk(nm, {28'h0, en, stp, rev, fwd}, {28'h0, exp});
  endtask

  // Waits for the gear request lines to become busy or quiet.
  task automatic wait_req(input logic busy);
    int n;
    n = 0;
    while (((gear_req != 3'h0) !== busy) && n < 200)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if ((gear_req != 3'h0) !== busy)
    begin
      chk("gear request wait", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("stop after reset", {en, stp, rev, fwd}, 32'h4);
    chk("gear req after reset", gear_req, 32'h0);
    chk("hresp", hresp, 32'h0);
    rchk("cmd reset", CMD_OFS, 32'hff, 32'h5);
    rchk("cfg reset", CFG_OFS, 32'h7f, 32'h20);
    rchk("frat reset", FRAT_OFS, 32'hff, 32'h1);
    rchk("spd1 reset", SPD1_OFS, 32'hffff, 32'h0);
    wr(8'h40, 32'h1234);
    rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
    wr(CMD_OFS, 32'h7);
    pins("unknown code", 4'h4);
    wr(CMD_OFS, {24'h0, SPINDLE_FORWARD_CODE});
    pins("forward pins", 4'h9);
    rchk("forward status", STAT_OFS, 32'h1e000, 32'h12000);
    repeat (20) @(posedge mclk);
    rchk("speed reached", STAT_OFS, 32'h60000, 32'h20000);
    wr(CMD_OFS, {24'h0, SPINDLE_REVERSE_CODE});
    pins("reverse pins", 4'ha);
    wr(CMD_OFS, {24'h0, SPINDLE_STOP_CODE});
    pins("stop pins", 4'h4);
    repeat (20) @(posedge mclk);
    rchk("zero speed", STAT_OFS, 32'h60000, 32'h40000);
    orient_cmd <= 1'b1;
    mode_cmd <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk("orient mode set", STAT_OFS, 32'h180000, 32'h180000);
    orient_cmd <= 1'b0;
    repeat (4) @(posedge mclk);
    rchk("orient clear", STAT_OFS, 32'h180000, 32'h100000);
    mode_cmd <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      wr(CFG_OFS, 32'h20 | s);
      rchk("fixed ratio", STAT_OFS, 32'hff, 32'h1 << s);
    end
    wr(FRAT_OFS, 32'h5);
    wr(CFG_OFS, 32'h27);
    rchk("free ratio", STAT_OFS, 32'hff, 32'h5);
    wr(CFG_OFS, 32'h38);
    rchk("io mismatch", STAT_OFS, 32'h1000, 32'h1000);
    wr(GEAR_OFS, 32'h2);
    repeat (6) @(posedge mclk);
    #1;
    chk("no shift under io", gear_req, 32'h0);
    wr(CFG_OFS, 32'h78);
    rchk("io config set", STAT_OFS, 32'h1000, 32'h0);
    wr(CFG_OFS, 32'h30);
    wr(CMD_OFS, {24'h0, SPINDLE_FORWARD_CODE});
    for (int g = 2; g != 0; g = (g == 3) ? 1 : (g == 1 ? 0 : g + 1))
    begin
      slow <= (g == 3);
      wr(GEAR_OFS, g);
      wait_req(1'b1);
      chk("gear request", gear_req, 32'h1 << (g - 1));
      chk("spindle paused", fwd, 32'h0);
      rchk("shift busy", STAT_OFS, 32'h400, 32'h400);
      wait_req(1'b0);
      pins("spindle resumed", 4'h9);
      rchk("current gear", GEAR_OFS, 32'h3, g);
    end
    rchk("gear in position", STAT_OFS, 32'he00400, 32'h200000);
    wr(CFG_OFS, 32'h10);
    hold_inpos <= 1'b1;
    wr(GEAR_OFS, 32'h2);
    wait_req(1'b1);
    wait_req(1'b0);
    rchk("shift without switch", GEAR_OFS, 32'h3, 32'h2);
    hold_inpos <= 1'b0;
    wr(CFG_OFS, 32'h20);
    rchk("gear one default", STAT_OFS, 32'h300, 32'h100);
    wr(GEAR_OFS, 32'h3);
    repeat (6) @(posedge mclk);
    #1;
    chk("no shift unfitted", gear_req, 32'h0);
    wr(SPD1_OFS, 32'd100);
    wr(SPD2_OFS, 32'd200);
    wr(SPD3_OFS, 32'd50);
    rchk("speed order bad", STAT_OFS, 32'h800, 32'h800);
    wr(SPD1_OFS, 32'd300);
    rchk("speed order good", STAT_OFS, 32'h800, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
